// ==== verif/mlf_top_properties.sv ====
`timescale 1ns/1ns
// ====
// Checks at the ports of the fault settings block.
module mlf_top_properties #(
    parameter int SPEED_W = 16,
    parameter int RETRY_CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [SPEED_W-1:0] speed_est_i,
    input wire logic [SPEED_W-1:0] speed_max_i,
    input wire logic [SPEED_W-1:0] backemf_meas_i,
    input wire logic [SPEED_W-1:0] backemf_expected_i,
    input wire logic absent_motor_detect_i,
    input wire logic initpos_freq_fault_raw_i,
    input wire logic current_loop_sat_i,
    input wire logic speed_loop_sat_i,
    input wire logic fault_output_low_o,
    input wire mlf_pkg::mlf_drive_t drive_o,
    input wire mlf_pkg::mlf_lock_t lock_flags_o,
    input wire logic initpos_freq_fault_o,
    input wire logic current_loop_sat_o,
    input wire logic speed_loop_sat_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sat_cur_a: assert property (current_loop_sat_o |-> $past(current_loop_sat_i))
        else $error("current loop saturation without cause");
    sat_spd_a: assert property (speed_loop_sat_o |-> $past(speed_loop_sat_i))
        else $error("speed loop saturation without cause");
    initpos_gate_a: assert property (initpos_freq_fault_o
        |-> $past(initpos_freq_fault_raw_i))
        else $error("initial position fault without cause");
    reg_store_a: assert property ($past(reg_wr_i && reg_addr_i == 8'h92) && !$past(rst_i)
        && reg_addr_i == 8'h92 |-> reg_rdata_o == ($past(reg_wdata_i) & 32'h7FFFFFFF))
        else $error("settings two does not hold the written word");
    absent_cause_a: assert property ($rose(lock_flags_o.absent)
        |-> $past(absent_motor_detect_i))
        else $error("absent motor flag without cause");
    overspeed_cause_a: assert property ($rose(lock_flags_o.overspeed)
        |-> $past(speed_est_i > speed_max_i))
        else $error("overspeed flag below maximum speed");
    backemf_cause_a: assert property ($rose(lock_flags_o.backemf)
        |-> $past(backemf_meas_i < backemf_expected_i))
        else $error("back-EMF flag above expected value");
    hiz_fault_a: assert property (drive_o.hiz |-> !fault_output_low_o)
        else $error("tristate without fault indication");
    drive_onehot_a: assert property ($onehot0(drive_o))
        else $error("more than one drive response");
    status_mirror_a: assert property (reg_addr_i == 8'h94
        |-> reg_rdata_o[2:0] == lock_flags_o && reg_rdata_o[7:5] == drive_o)
        else $error("status word does not mirror outputs");
endmodule

bind mlf_top mlf_top_properties #(.SPEED_W(SPEED_W), .RETRY_CYCLES(RETRY_CYCLES)) u_props (
    .clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .speed_est_i,
    .speed_max_i, .backemf_meas_i, .backemf_expected_i, .absent_motor_detect_i,
    .initpos_freq_fault_raw_i, .current_loop_sat_i, .speed_loop_sat_i, .fault_output_low_o,
    .drive_o, .lock_flags_o, .initpos_freq_fault_o, .current_loop_sat_o, .speed_loop_sat_o);

// ==== verif/motor_lock_fault_config_bench.sv ====
`timescale 1ns/1ns
`define CMP(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module motor_lock_fault_config_bench;
    typedef struct {string n; int s; logic [31:0] e;} mlf_note_t;
    mlf_note_t q[$];
    mlf_note_t nt;
    int n_mismatch = 0, samples_checked = 0, i;
    logic clk_i = 0, rst_i = 1, reg_wr_i = 0, absent_motor_detect_i = 0, fault_clear_i = 0;
    logic initpos_freq_fault_raw_i = 0, current_loop_sat_i = 0, speed_loop_sat_i = 0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, r = 32'h8B3C7069;
    logic [15:0] speed_est_i = 16'h0, speed_max_i = 16'h64;
    logic [15:0] backemf_meas_i = 16'h100, backemf_expected_i = 16'hC8;
    logic [15:0] th [8] = '{16'h50, 16'h5A, 16'h64, 16'h6E, 16'h78, 16'h82, 16'h87, 16'h8C};
    logic [6:0] dr [6] = '{7'h21, 7'h21, 7'h11, 7'h09, 7'h01, 7'h40};
    logic [31:0] md [6] = '{32'h0, 32'h8, 32'h10, 32'h18, 32'h40, 32'h48};
    logic fault_output_low_o, initpos_freq_fault_o, current_loop_sat_o, speed_loop_sat_o;
    mlf_pkg::mlf_drive_t drive_o;
    mlf_pkg::mlf_lock_t lock_flags_o;
    mlf_top #(.SPEED_W(16), .RETRY_CYCLES(20)) DUT (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
        .reg_wdata_i, .reg_rdata_o, .speed_est_i, .speed_max_i, .backemf_meas_i,
        .backemf_expected_i, .absent_motor_detect_i, .initpos_freq_fault_raw_i,
        .current_loop_sat_i, .speed_loop_sat_i, .fault_clear_i, .fault_output_low_o, .drive_o,
        .lock_flags_o, .initpos_freq_fault_o, .current_loop_sat_o, .speed_loop_sat_o);
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // ====
    // Notes are checked at the falling edge, after the driver has settled its inputs.
    function automatic logic [31:0] obs(int s);
        if (s == 0) return reg_rdata_o;
        if (s == 1) return {25'h0, fault_output_low_o, drive_o, lock_flags_o};
        return {29'h0, initpos_freq_fault_o, current_loop_sat_o, speed_loop_sat_o};
    endfunction
    always @(negedge clk_i) begin
        while (q.size() > 0) begin
            nt = q.pop_front();
            `CMP(nt.n, nt.e, obs(nt.s))
        end
    end
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function void note(string n, int s, logic [31:0] e);
        q.push_back('{n, s, e});
    endfunction
    task tick;
        @(posedge clk_i);
        #2;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        tick;
        reg_wr_i = 0;
        tick;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr_i = a;
        note("rdata", 0, e);
        tick;
    endtask
    task clr;
        absent_motor_detect_i = 0;
        speed_est_i = 16'h0;
        backemf_meas_i = 16'h100;
        fault_clear_i = 1;
        tick;
        fault_clear_i = 0;
        note("clear", 1, 32'h40);
        tick;
    endtask
    task lock(input logic [31:0] c, input logic [15:0] ok, bad, input logic [6:0] e, input int k);
        wr(8'h92, c);
        if (k) backemf_meas_i = ok; else speed_est_i = ok;
        tick;
        note("edge", 1, 32'h40);
        if (k) backemf_meas_i = bad; else speed_est_i = bad;
        tick;
        note("lock", 1, e);
        clr;
    endtask
    task wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        wrap_up;
    end
    // ====
    // Test sequence.
    initial begin
        repeat (3) tick;
        rst_i = 0;
        rd(8'h90, 32'h0);
        rd(8'h92, 32'h0);
        rd(8'h94, 32'h0);
        r = lfsr(r);
        wr(8'h92, r);
        rd(8'h92, r & 32'h7FFFFFFF);
        wr(8'h94, r);
        wr(8'h5A, r);
        rd(8'h94, 32'h0);
        rd(8'h5A, 32'h0);
        $display("register test done");
        for (i = 0; i < 8; i++) begin
            wr(8'h90, 32'(i % 4));
            r = lfsr(r);
            {initpos_freq_fault_raw_i, current_loop_sat_i, speed_loop_sat_i} = r[2:0];
            tick;
            note("gate", 2, {r[2] & (i % 4 > 1), r[1] & i[0], r[0] & i[0]});
            tick;
        end
        $display("gating test done");
        for (i = 0; i < 8; i++) begin
            lock(32'h40000000 | (32'(i) << 25), 16'(130 + 10 * i), 16'(131 + 10 * i), 7'h24, 0);
            lock(32'h20000000 | (32'(i) << 22), th[i], th[i] - 16'h1, 7'h22, 1);
        end
        lock(32'h1FC00000, 16'h82, 16'hFA, 7'h40, 0);
        lock(32'h4FC00000, 16'h50, 16'h0A, 7'h40, 1);
        $display("threshold test done");
        for (i = 0; i < 7; i++) begin
            wr(8'h92, i == 6 ? 32'h0 : 32'h10000000);
            wr(8'h90, i == 6 ? 32'h0 : md[i]);
            absent_motor_detect_i = 1;
            tick;
            note("absent", 1, i == 6 ? 32'h40 : dr[i]);
            clr;
        end
        wr(8'h92, 32'h10000000);
        absent_motor_detect_i = 1;
        tick;
        fault_clear_i = 1;
        tick;
        fault_clear_i = 0;
        note("clear vs hit", 1, 32'h21);
        rd(8'h94, 32'h89);
        clr;
        for (i = 4; i < 8; i++) begin
            wr(8'h90, 32'(i) << 3);
            absent_motor_detect_i = 1;
            tick;
            absent_motor_detect_i = 0;
            note("retry", 1, dr[i - 4]);
            repeat (19) tick;
            note("retry hold", 1, dr[i - 4]);
            tick;
            note("retry end", 1, 32'h40);
        end
        absent_motor_detect_i = 1;
        tick;
        rst_i = 1;
        tick;
        rst_i = 0;
        absent_motor_detect_i = 0;
        note("reset", 1, 32'h40);
        rd(8'h92, 32'h0);
        $display("response test done");
        wrap_up;
    end
endmodule

// ==== verilog/mlf_map.svh ====
`ifndef MLF_MAP_SVH
`define MLF_MAP_SVH

// ============================================================
// Register offsets
`define MLF_OFS_SETTINGS_ONE 8'h90
`define MLF_OFS_SETTINGS_TWO 8'h92
`define MLF_OFS_STATUS 8'h94

// ============================================================
// Settings one field positions
`define MLF_SAT_EN_BIT 0
`define MLF_INITPOS_EN_BIT 1
`define MLF_MODE_LSB 3
`define MLF_MODE_MSB 6

// ============================================================
// Settings two field positions
`define MLF_RSVD_BIT 31
`define MLF_OVERSPEED_EN_BIT 30
`define MLF_BACKEMF_EN_BIT 29
`define MLF_ABSENT_EN_BIT 28
`define MLF_OVERSPEED_THR_LSB 25
`define MLF_OVERSPEED_THR_MSB 27
`define MLF_BACKEMF_THR_LSB 22
`define MLF_BACKEMF_THR_MSB 24

// ============================================================
// Reset values
`define MLF_SETTINGS_ONE_RST 32'h00000000
`define MLF_SETTINGS_TWO_RST 32'h00000000

// ============================================================
// Thresholds in tenths of a percent
`define MLF_OVERSPEED_BASE 11'h514
`define MLF_OVERSPEED_STEP 11'h064
`define MLF_BACKEMF_BASE 11'h190
`define MLF_BACKEMF_STEP 11'h032
`define MLF_BACKEMF_CODE6 11'h2A3
`define MLF_BACKEMF_CODE7 11'h2BC
`define MLF_PERMILLE_FULL 11'h3E8

// ============================================================
// Mode codes and timing
`define MLF_MODE_REPORT 4'h8
`define MLF_CLK_HZ 20000000
`define MLF_RETRY_MS 300
`define MLF_RETRY_CYCLES (`MLF_RETRY_MS * (`MLF_CLK_HZ / 1000))

`endif

// ==== verilog/mlf_pkg.sv ====
package mlf_pkg;

    typedef struct packed {
        logic overspeed;
        logic backemf;
        logic absent;
    } mlf_lock_t;

    typedef struct packed {
        logic hiz;
        logic brake_high;
        logic brake_low;
    } mlf_drive_t;

    typedef enum logic [1:0] {
        MLF_RUN,
        MLF_LATCHED,
        MLF_RETRY
    } mlf_state_t;

endpackage

// ==== verilog/mlf_ratio_cmp.sv ====
`timescale 1ns/1ns
`include "mlf_map.svh"

module mlf_ratio_cmp #(
    parameter int W = 16
) (
    input wire logic [W-1:0] value_i,
    input wire logic [W-1:0] ref_i,
    input wire logic [10:0] permille_i,
    output logic above_o,
    output logic below_o
);

    // ============================================================
    // Scaled comparison
    // Both sides are widened to a common width so neither product overflows.
    logic [W+10:0] scaled_value;
    logic [W+10:0] scaled_ref;

    always_comb begin
        scaled_value = (W+11)'(value_i) * (W+11)'(`MLF_PERMILLE_FULL);
        scaled_ref = (W+11)'(ref_i) * (W+11)'(permille_i);
        above_o = scaled_value > scaled_ref;
        below_o = scaled_value < scaled_ref;
    end

endmodule

// ==== verilog/mlf_top.sv ====
// What this block does
// R01 - Initial position frequency fault is raised only when its enable bit is set.
// R02 - Loop saturation indications appear only when the saturation enable bit is set.
// R03 - Overspeed lock detector works only while its enable bit is one.
// R04 - Back-EMF lock detector works only while its enable bit is one.
// R05 - Absent-motor lock detector works only while its enable bit is one.
// R06 - Overspeed threshold is 130 percent plus 10 percent per code.
// R07 - Back-EMF threshold codes give 40 to 65, then 67.5 and 70 percent.
// R08 - A firing enabled detector triggers the response that the stall mode selects.
// R09 - Overspeed flags above threshold; back-EMF flags below its threshold.
`timescale 1ns/1ns
`include "mlf_map.svh"

module mlf_top #(
    parameter int SPEED_W = 16,
    parameter int RETRY_CYCLES = `MLF_RETRY_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [SPEED_W-1:0] speed_est_i,
    input wire logic [SPEED_W-1:0] speed_max_i,
    input wire logic [SPEED_W-1:0] backemf_meas_i,
    input wire logic [SPEED_W-1:0] backemf_expected_i,
    input wire logic absent_motor_detect_i,
    input wire logic initpos_freq_fault_raw_i,
    input wire logic current_loop_sat_i,
    input wire logic speed_loop_sat_i,
    input wire logic fault_clear_i,
    output logic fault_output_low_o,
    output mlf_pkg::mlf_drive_t drive_o,
    output mlf_pkg::mlf_lock_t lock_flags_o,
    output logic initpos_freq_fault_o,
    output logic current_loop_sat_o,
    output logic speed_loop_sat_o
);

    if (SPEED_W < 4 || SPEED_W > 32) begin
        $error("SPEED_W out of range");
    end
    if (RETRY_CYCLES < 1) begin
        $error("RETRY_CYCLES must be positive");
    end

    // ============================================================
    // Register bank
    logic [31:0] settings_one_q;
    logic [31:0] settings_one_d;
    logic [31:0] settings_two_q;
    logic [31:0] settings_two_d;
    logic [31:0] one_mask;

    always_comb begin
        one_mask = 32'h00000000;
        one_mask[`MLF_SAT_EN_BIT] = 1'b1;
        one_mask[`MLF_INITPOS_EN_BIT] = 1'b1;
        one_mask[`MLF_MODE_MSB:`MLF_MODE_LSB] = 4'hF;
        settings_one_d = settings_one_q;
        settings_two_d = settings_two_q;
        if (reg_wr_i && reg_addr_i == `MLF_OFS_SETTINGS_ONE) begin
            settings_one_d = reg_wdata_i & one_mask;
        end
        if (reg_wr_i && reg_addr_i == `MLF_OFS_SETTINGS_TWO) begin
            settings_two_d = reg_wdata_i;
            settings_two_d[`MLF_RSVD_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settings_one_q <= `MLF_SETTINGS_ONE_RST;
            settings_two_q <= `MLF_SETTINGS_TWO_RST;
        end else begin
            settings_one_q <= settings_one_d;
            settings_two_q <= settings_two_d;
        end
    end

    // ============================================================
    // Field decode
    logic [3:0] mode;
    logic [2:0] overspeed_code;
    logic [2:0] backemf_code;
    logic [10:0] overspeed_permille;
    logic [10:0] backemf_permille;

    always_comb begin
        mode = settings_one_q[`MLF_MODE_MSB:`MLF_MODE_LSB];
        overspeed_code = settings_two_q[`MLF_OVERSPEED_THR_MSB:`MLF_OVERSPEED_THR_LSB];
        backemf_code = settings_two_q[`MLF_BACKEMF_THR_MSB:`MLF_BACKEMF_THR_LSB];
        overspeed_permille = `MLF_OVERSPEED_BASE
            + 11'(overspeed_code) * `MLF_OVERSPEED_STEP; // R06
        case (backemf_code) // R07
            3'h6: backemf_permille = `MLF_BACKEMF_CODE6;
            3'h7: backemf_permille = `MLF_BACKEMF_CODE7;
            default: backemf_permille = `MLF_BACKEMF_BASE
                + 11'(backemf_code) * `MLF_BACKEMF_STEP;
        endcase
    end

    // ============================================================
    // Lock detectors
    logic overspeed_above;
    logic backemf_below;

    mlf_ratio_cmp #(
        .W(SPEED_W)
    ) u_overspeed_cmp (
        .value_i(speed_est_i),
        .ref_i(speed_max_i),
        .permille_i(overspeed_permille),
        .above_o(overspeed_above),
        .below_o()
    );

    mlf_ratio_cmp #(
        .W(SPEED_W)
    ) u_backemf_cmp (
        .value_i(backemf_meas_i),
        .ref_i(backemf_expected_i),
        .permille_i(backemf_permille),
        .above_o(),
        .below_o(backemf_below)
    );

    mlf_pkg::mlf_lock_t hit;

    always_comb begin
        hit.overspeed = settings_two_q[`MLF_OVERSPEED_EN_BIT] && overspeed_above; // R03 R09
        hit.backemf = settings_two_q[`MLF_BACKEMF_EN_BIT] && backemf_below; // R04 R09
        hit.absent = settings_two_q[`MLF_ABSENT_EN_BIT] && absent_motor_detect_i; // R05
    end

    // ============================================================
    // Stall response
    // Modes 0-3 latch until cleared, 4-7 release after the retry time,
    // 8 only reports, and anything above 8 ignores the detectors.
    mlf_pkg::mlf_state_t state_q;
    mlf_pkg::mlf_state_t state_d;
    mlf_pkg::mlf_lock_t flags_q;
    mlf_pkg::mlf_lock_t flags_d;
    mlf_pkg::mlf_drive_t drive_q;
    mlf_pkg::mlf_drive_t drive_d;
    mlf_pkg::mlf_drive_t action;
    logic [31:0] retry_q;
    logic [31:0] retry_d;
    logic fault_low_q;
    logic fault_low_d;
    logic any_hit;
    logic acting;

    always_comb begin
        any_hit = |hit;
        acting = (mode[3] == 1'b0);
        action.hiz = (mode[1:0] == 2'h0) || (mode[1:0] == 2'h1);
        action.brake_high = (mode[1:0] == 2'h2);
        action.brake_low = (mode[1:0] == 2'h3);
        state_d = state_q;
        retry_d = retry_q;
        drive_d = drive_q;
        flags_d = flags_q;
        if (fault_clear_i) begin
            flags_d = '0;
        end
        if (mode <= `MLF_MODE_REPORT) begin
            flags_d = flags_d | hit; // R08
        end
        case (state_q)
            mlf_pkg::MLF_RUN: begin
                drive_d = '0;
                if (any_hit && acting) begin // R08
                    drive_d = action;
                    retry_d = 32'h00000000;
                    state_d = mode[2] ? mlf_pkg::MLF_RETRY : mlf_pkg::MLF_LATCHED;
                end
            end
            mlf_pkg::MLF_LATCHED: begin
                if (fault_clear_i && !any_hit) begin
                    drive_d = '0;
                    state_d = mlf_pkg::MLF_RUN;
                end
            end
            mlf_pkg::MLF_RETRY: begin
                retry_d = retry_q + 32'h00000001;
                if (retry_q >= 32'(RETRY_CYCLES - 1)) begin
                    drive_d = '0;
                    flags_d = hit;
                    state_d = mlf_pkg::MLF_RUN;
                end
            end
            default: begin
                drive_d = '0;
                state_d = mlf_pkg::MLF_RUN;
            end
        endcase
        fault_low_d = !((state_d != mlf_pkg::MLF_RUN)
            || (mode == `MLF_MODE_REPORT && any_hit)); // R08
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= mlf_pkg::MLF_RUN;
            flags_q <= '0;
            drive_q <= '0;
            retry_q <= 32'h00000000;
            fault_low_q <= 1'b1;
        end else begin
            state_q <= state_d;
            flags_q <= flags_d;
            drive_q <= drive_d;
            retry_q <= retry_d;
            fault_low_q <= fault_low_d;
        end
    end

    // ============================================================
    // Gated indications
    logic initpos_q;
    logic initpos_d;
    logic cur_sat_q;
    logic cur_sat_d;
    logic spd_sat_q;
    logic spd_sat_d;

    always_comb begin
        initpos_d = settings_one_q[`MLF_INITPOS_EN_BIT] && initpos_freq_fault_raw_i; // R01
        cur_sat_d = settings_one_q[`MLF_SAT_EN_BIT] && current_loop_sat_i; // R02
        spd_sat_d = settings_one_q[`MLF_SAT_EN_BIT] && speed_loop_sat_i; // R02
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            initpos_q <= 1'b0;
            cur_sat_q <= 1'b0;
            spd_sat_q <= 1'b0;
        end else begin
            initpos_q <= initpos_d;
            cur_sat_q <= cur_sat_d;
            spd_sat_q <= spd_sat_d;
        end
    end

    // ============================================================
    // Read path and outputs
    always_comb begin
        case (reg_addr_i)
            `MLF_OFS_SETTINGS_ONE: reg_rdata_o = settings_one_q;
            `MLF_OFS_SETTINGS_TWO: reg_rdata_o = settings_two_q;
            `MLF_OFS_STATUS: reg_rdata_o = {24'h000000, drive_q, state_q, flags_q};
            default: reg_rdata_o = 32'h00000000;
        endcase
    end

    assign fault_output_low_o = fault_low_q;
    assign drive_o = drive_q;
    assign lock_flags_o = flags_q;
    assign initpos_freq_fault_o = initpos_q;
    assign current_loop_sat_o = cur_sat_q;
    assign speed_loop_sat_o = spd_sat_q;

endmodule
